// [design/strap_cfg_regs.svh]
/*
  Offsets, field positions and reset values of the strap-loaded register bank.
  Assumes inclusion by bare name from the design files.
*/
`ifndef STRAP_CFG_REGS_SVH
`define STRAP_CFG_REGS_SVH

// Register indices, in the order the serial port addresses them
`define IDX_HIGH_SPEED_MODE      3'h0
`define IDX_AUXILIARY_MODE       3'h1
`define IDX_RECEIVER_SETTINGS    3'h2
`define IDX_INPUT_TERM_AB        3'h3
`define IDX_INPUT_TERM_CD        3'h4
`define IDX_EQUALIZER_AB         3'h5
`define IDX_EQUALIZER_CD         3'h6
`define IDX_TRANSMITTER_SETTINGS 3'h7

// Field positions
`define ENABLE_BIT               6
`define SELECT_LSB               0
`define TERM_MASTER_BIT          0
`define PREEMPH_LSB              2
`define OUT_TERM_BIT             1
`define OUT_CURRENT_BIT          0

// Fixed strap-mode values and the register reset value
`define AUX_ENABLE_FORCED        1'h1
`define INPUT_TERM_STRAP         8'h00
`define RX_SETTINGS_STRAP        8'h01
`define REG_RESET                8'h00

`endif

// [design/strap_cfg_pkg.sv]
/*
  Types shared by the strap configuration loader.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package strap_cfg_pkg;
  typedef enum logic [1:0] {SRC_A, SRC_B, SRC_C, SRC_D} source_sel_t;
  typedef enum logic [1:0] {PE_0DB, PE_2DB, PE_4DB, PE_6DB} preemph_t;
  typedef enum {LOAD_STRAPS, SERIAL_OWNED} owner_state_t;
endpackage

// [design/term_decode.sv]
/*
  Per-lane input termination switch decode.
  Assumes the register bank supplies the master bit and sixteen per-lane bits.
*/
`timescale 1ns/10ps
module term_decode
  import strap_cfg_pkg::*;
(
  // Control
  input  wire logic        input_term_master,
  input  wire logic [15:0] input_term_per_lane,
  // Switches
  output logic      [15:0] term_switch_on
);
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_lane
      assign term_switch_on[i] = input_term_master & input_term_per_lane[i];
    end
  endgenerate
endmodule

// [design/parallel_strap_config_loader.sv]
/*
  Register bank of the 4:1 video link switch, loaded from strap pins after
  reset until the first serial access, plus decode of the analog controls.
  Assumes straps are static and synchronous; the serial port supplies a
  one-cycle access strobe with index and write data.
*/
`timescale 1ns/10ps
`include "strap_cfg_regs.svh"
module parallel_strap_config_loader
  import strap_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Strap pins
  input  wire logic        lane_enable_strap,
  input  wire logic [1:0]  source_select_strap,
  input  wire logic        equalizer_strap,
  input  wire logic [1:0]  preemph_level_strap,
  input  wire logic        out_termination_strap,
  input  wire logic        out_current_strap,
  // Serial register port
  input  wire logic        ser_access,
  input  wire logic        ser_write,
  input  wire logic [2:0]  ser_index,
  input  wire logic [7:0]  ser_wdata,
  output logic      [7:0]  ser_rdata,
  output logic             straps_detached,
  // Register views
  output logic      [7:0]  high_speed_mode_reg,
  output logic      [7:0]  auxiliary_mode_reg,
  output logic      [7:0]  receiver_settings_reg,
  output logic      [7:0]  input_termination_ab_reg,
  output logic      [7:0]  input_termination_cd_reg,
  output logic      [7:0]  equalizer_ab_reg,
  output logic      [7:0]  equalizer_cd_reg,
  output logic      [7:0]  transmitter_settings_reg,
  // Decoded controls
  output logic             lanes_on,
  output logic             standby,
  output source_sel_t      hs_source,
  output logic             aux_switch_on,
  output source_sel_t      aux_source,
  output logic      [15:0] eq_high,
  output logic      [15:0] term_switch_on,
  output preemph_t         preemph_level,
  output logic             out_term_on,
  output logic             out_current_high
);

  owner_state_t owner_reg;
  logic [7:0]   hs_strap;
  logic [7:0]   aux_strap;
  logic [7:0]   eq_strap;
  logic [7:0]   tx_strap;
  logic         strap_phase;
  logic [7:0]   wr_sel;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      owner_reg <= LOAD_STRAPS;
    end else begin
      case (owner_reg)
        LOAD_STRAPS: begin
          if (ser_access) begin
            owner_reg <= SERIAL_OWNED;
          end
        end
        SERIAL_OWNED: owner_reg <= SERIAL_OWNED;
        default:      owner_reg <= LOAD_STRAPS;
      endcase
    end
  end

  assign strap_phase     = (owner_reg == LOAD_STRAPS) && !ser_access;
  assign straps_detached = (owner_reg == SERIAL_OWNED);

  assign hs_strap  = {1'b0, lane_enable_strap, 4'h0, source_select_strap};
  assign aux_strap = {1'b0, `AUX_ENABLE_FORCED, 4'h0, source_select_strap};
  assign eq_strap  = {8{equalizer_strap}};
  assign tx_strap  = {4'h0, preemph_level_strap, out_termination_strap, out_current_strap};

  genvar r;
  generate
    for (r = 0; r < 8; r = r + 1) begin : g_wsel
      assign wr_sel[r] = ser_access && ser_write && (ser_index == 3'(r));
    end
  endgenerate

  // Straps are static; reloading them every cycle makes pin edits visible
  // on the next edge until the first serial access, with no reset needed.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      high_speed_mode_reg <= `REG_RESET;
    end else if (strap_phase) begin
      high_speed_mode_reg <= hs_strap;
    end else if (wr_sel[`IDX_HIGH_SPEED_MODE]) begin
      high_speed_mode_reg <= ser_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      auxiliary_mode_reg <= `REG_RESET;
    end else if (strap_phase) begin
      auxiliary_mode_reg <= aux_strap;
    end else if (wr_sel[`IDX_AUXILIARY_MODE]) begin
      auxiliary_mode_reg <= ser_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      receiver_settings_reg <= `REG_RESET;
    end else if (strap_phase) begin
      receiver_settings_reg <= `RX_SETTINGS_STRAP;
    end else if (wr_sel[`IDX_RECEIVER_SETTINGS]) begin
      receiver_settings_reg <= ser_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      input_termination_ab_reg <= `REG_RESET;
      input_termination_cd_reg <= `REG_RESET;
    end else if (strap_phase) begin
      input_termination_ab_reg <= `INPUT_TERM_STRAP;
      input_termination_cd_reg <= `INPUT_TERM_STRAP;
    end else begin
      if (wr_sel[`IDX_INPUT_TERM_AB]) begin
        input_termination_ab_reg <= ser_wdata;
      end
      if (wr_sel[`IDX_INPUT_TERM_CD]) begin
        input_termination_cd_reg <= ser_wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      equalizer_ab_reg <= `REG_RESET;
      equalizer_cd_reg <= `REG_RESET;
    end else if (strap_phase) begin
      equalizer_ab_reg <= eq_strap;
      equalizer_cd_reg <= eq_strap;
    end else begin
      if (wr_sel[`IDX_EQUALIZER_AB]) begin
        equalizer_ab_reg <= ser_wdata;
      end
      if (wr_sel[`IDX_EQUALIZER_CD]) begin
        equalizer_cd_reg <= ser_wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      transmitter_settings_reg <= `REG_RESET;
    end else if (strap_phase) begin
      transmitter_settings_reg <= tx_strap;
    end else if (wr_sel[`IDX_TRANSMITTER_SETTINGS]) begin
      transmitter_settings_reg <= ser_wdata;
    end
  end

  // Read data registered; index decoded in the access cycle, data valid one cycle after
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ser_rdata <= 8'h00;
    end else if (ser_access && !ser_write) begin
      case (ser_index)
        `IDX_HIGH_SPEED_MODE:      ser_rdata <= high_speed_mode_reg;
        `IDX_AUXILIARY_MODE:       ser_rdata <= auxiliary_mode_reg;
        `IDX_RECEIVER_SETTINGS:    ser_rdata <= receiver_settings_reg;
        `IDX_INPUT_TERM_AB:        ser_rdata <= input_termination_ab_reg;
        `IDX_INPUT_TERM_CD:        ser_rdata <= input_termination_cd_reg;
        `IDX_EQUALIZER_AB:         ser_rdata <= equalizer_ab_reg;
        `IDX_EQUALIZER_CD:         ser_rdata <= equalizer_cd_reg;
        `IDX_TRANSMITTER_SETTINGS: ser_rdata <= transmitter_settings_reg;
        default:                   ser_rdata <= 8'h00;
      endcase
    end
  end

  assign lanes_on      = high_speed_mode_reg[`ENABLE_BIT];
  assign standby       = ~high_speed_mode_reg[`ENABLE_BIT];
  assign hs_source     = source_sel_t'(high_speed_mode_reg[`SELECT_LSB +: 2]);
  assign aux_switch_on = auxiliary_mode_reg[`ENABLE_BIT];
  assign aux_source    = source_sel_t'(auxiliary_mode_reg[`SELECT_LSB +: 2]);
  assign eq_high       = {equalizer_cd_reg, equalizer_ab_reg};
  assign preemph_level = preemph_t'(transmitter_settings_reg[`PREEMPH_LSB +: 2]);
  assign out_term_on   = transmitter_settings_reg[`OUT_TERM_BIT];
  assign out_current_high = transmitter_settings_reg[`OUT_CURRENT_BIT];

  term_decode u_term (
    .input_term_master   (receiver_settings_reg[`TERM_MASTER_BIT]),
    .input_term_per_lane ({input_termination_cd_reg, input_termination_ab_reg}),
    .term_switch_on      (term_switch_on)
  );

  strap_hs_a: assert property (@(posedge mclk) disable iff (!rst_n)
    strap_phase |=> high_speed_mode_reg == $past(hs_strap))
    else $error("high-speed mode did not follow straps");
  strap_aux_a: assert property (@(posedge mclk) disable iff (!rst_n)
    strap_phase |=> auxiliary_mode_reg == {2'b01, 4'h0, $past(source_select_strap)})
    else $error("auxiliary mode did not follow straps");
  term_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    strap_phase |=> (input_termination_ab_reg | input_termination_cd_reg) == 8'h00)
    else $error("termination register nonzero under straps");
  term_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !straps_detached |-> term_switch_on == 16'h0000)
    else $error("termination switch on while straps own bank");
  eq_copy_a: assert property (@(posedge mclk) disable iff (!rst_n)
    strap_phase |=> eq_high == {16{$past(equalizer_strap)}})
    else $error("equalizer bits differ from strap");
  tx_copy_a: assert property (@(posedge mclk) disable iff (!rst_n)
    strap_phase |=> transmitter_settings_reg[3:0] ==
      {$past(preemph_level_strap), $past(out_termination_strap), $past(out_current_strap)})
    else $error("transmitter settings differ from straps");
  sequence first_access_s;
    !straps_detached ##0 ser_access;
  endsequence
  detach_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    first_access_s ##1 (!ser_access) [*3] |->
      $stable(high_speed_mode_reg) && $stable(transmitter_settings_reg))
    else $error("straps changed register after serial access");
  flag_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ser_access |=> straps_detached [*3])
    else $error("detach flag not held after access");
  standby_a: assert property (@(posedge mclk) disable iff (!rst_n)
    standby == !lanes_on)
    else $error("standby and lane enable disagree");
  sequence term_write_s;
    ser_access && ser_write && (ser_index == `IDX_INPUT_TERM_AB);
  endsequence
  term_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    term_write_s |=> input_termination_ab_reg == $past(ser_wdata))
    else $error("termination write did not land");
  sequence term_read_s;
    ser_access && !ser_write && (ser_index == `IDX_INPUT_TERM_AB);
  endsequence
  term_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    term_read_s |=> ser_rdata == $past(input_termination_ab_reg))
    else $error("read data differs from termination register");
  rx_strap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    strap_phase |=> receiver_settings_reg == `RX_SETTINGS_STRAP)
    else $error("receiver settings differ from strap image");
  term_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !receiver_settings_reg[`TERM_MASTER_BIT] |-> term_switch_on == 16'h0000)
    else $error("termination switch on with master bit clear");
  term_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
    receiver_settings_reg[`TERM_MASTER_BIT] |->
      term_switch_on == {input_termination_cd_reg, input_termination_ab_reg})
    else $error("termination switches differ from per-lane bits");
  detach_freeze_a: assert property (@(posedge mclk) disable iff (!rst_n)
    straps_detached && !ser_access |=>
      $stable(high_speed_mode_reg) && $stable(transmitter_settings_reg) &&
      $stable(equalizer_cd_reg))
    else $error("register changed without serial access after detach");
  flag_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    straps_detached |=> straps_detached)
    else $error("detach flag dropped without reset");

endmodule

// [sim/strap_board.sv]
/*
  Board strap ties and system reset controller around the loader.
  Assumes the bench sets the strap word and may ask for a reset.
*/
`timescale 1ns/10ps
module strap_board (
  // Bench side
  input  wire logic       mclk,
  input  wire logic [7:0] strap_word,
  input  wire logic       reset_req,
  // Pins
  output logic            rst_n,
  output logic            lane_enable_strap,
  output logic [1:0]      source_select_strap,
  output logic            equalizer_strap,
  output logic [1:0]      preemph_level_strap,
  output logic            out_termination_strap,
  output logic            out_current_strap
);
  logic [1:0] sel_seen;

  // Release lands just after the edge, never in the edge's own time step
  always @(posedge mclk) begin
    sel_seen <= #2 strap_word[6:5];
  end

  // reset on select change
  // Unknown history at power-up also reads as a change
  assign rst_n = !reset_req && (sel_seen === strap_word[6:5]);
  assign {lane_enable_strap, source_select_strap, equalizer_strap, preemph_level_strap,
          out_termination_strap, out_current_strap} = strap_word;
endmodule

// [sim/test_parallel_strap_config_loader.sv]
/*
  Self-checking bench for the strap configuration loader.
  Assumes the board model drives straps and reset; serial port driven here.
*/
`timescale 1ns/10ps
`include "strap_cfg_regs.svh"
module test_parallel_strap_config_loader;
  typedef struct packed {logic [7:0] word, hs, aux, eq, tx;} row_t;
  // Strap word {en, sel[1:0], eq, pe[1:0], oto, ocl}
  row_t rows [4] = '{'{8'h81, 8'h40, 8'h40, 8'h00, 8'h01}, '{8'h36, 8'h01, 8'h41, 8'hff, 8'h06},
                    '{8'hc8, 8'h42, 8'h42, 8'h00, 8'h08}, '{8'h7f, 8'h03, 8'h43, 8'hff, 8'h0f}};
  row_t        r;
  logic        mclk, rst_n, reset_req, ser_access, ser_write;
  logic [7:0]  strap_word, ser_wdata, ser_rdata;
  logic [2:0]  ser_index;
  logic        en, eq, oto, ocl, detached, lanes_on, standby, aux_on, oto_on, cur_hi;
  logic [1:0]  sel, pe, hs_src, aux_src, pe_lvl;
  logic [7:0]  hs_r, aux_r, rx_r, tab_r, tcd_r, eab_r, ecd_r, tx_r;
  logic [15:0] eq_high, term_on;
  int          err_total, cmp_count;

  strap_board u_board (.mclk(mclk), .strap_word(strap_word), .reset_req(reset_req),
    .rst_n(rst_n), .lane_enable_strap(en), .source_select_strap(sel), .equalizer_strap(eq),
    .preemph_level_strap(pe), .out_termination_strap(oto), .out_current_strap(ocl));
  parallel_strap_config_loader u_dut (.mclk(mclk), .rst_n(rst_n), .lane_enable_strap(en),
    .source_select_strap(sel), .equalizer_strap(eq), .preemph_level_strap(pe),
    .out_termination_strap(oto), .out_current_strap(ocl), .ser_access(ser_access),
    .ser_write(ser_write), .ser_index(ser_index), .ser_wdata(ser_wdata),
    .ser_rdata(ser_rdata), .straps_detached(detached), .high_speed_mode_reg(hs_r),
    .auxiliary_mode_reg(aux_r), .receiver_settings_reg(rx_r),
    .input_termination_ab_reg(tab_r), .input_termination_cd_reg(tcd_r),
    .equalizer_ab_reg(eab_r), .equalizer_cd_reg(ecd_r), .transmitter_settings_reg(tx_r),
    .lanes_on(lanes_on), .standby(standby), .hs_source(hs_src), .aux_switch_on(aux_on),
    .aux_source(aux_src), .eq_high(eq_high), .term_switch_on(term_on),
    .preemph_level(pe_lvl), .out_term_on(oto_on), .out_current_high(cur_hi));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Extra cycle after release keeps strobes from being set twice in one step
  task automatic ser(input logic wr, input logic [2:0] idx, input logic [7:0] d);
    ser_access = 1'b1;
    ser_write = wr;
    ser_index = idx;
    ser_wdata = d;
    tick(1);
    ser_access = 1'b0;
    tick(1);
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // About 31 cycles expected; generous margin
  initial begin
    #20000;
    err_total++;
    test_done;
  end

  initial begin
    strap_word = rows[0].word;
    reset_req = 1'b1;
    ser_access = 1'b0;
    ser_write = 1'b0;
    ser_index = 3'h0;
    ser_wdata = 8'h00;
    tick(1);
    chk("reset_regs", {hs_r, tx_r}, 16'h0000);
    chk("reset_flags", {detached, lanes_on, standby}, 3'b001);
    tick(1);
    reset_req = 1'b0;
    // Each row after the first changes the select, so the board pulses reset
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      strap_word = r.word;
      tick(3);
      chk("hs_mode", {hs_r, lanes_on, standby, hs_src}, {r.hs, r.hs[6], ~r.hs[6], r.hs[1:0]});
      chk("aux_mode", {aux_r, aux_on, aux_src}, {r.aux, 1'b1, r.hs[1:0]});
      chk("term_regs", {tcd_r, tab_r}, 16'h0000);
      chk("term_on", term_on, 16'h0000);
      chk("eq_regs", {ecd_r, eab_r}, {2{r.eq}});
      chk("eq_high", eq_high, {2{r.eq}});
      chk("tx_set", {tx_r, pe_lvl, oto_on, cur_hi}, {r.tx, r.tx[3:0]});
      chk("rx_set", rx_r, 8'h01);
    end
    ser(1'b1, `IDX_EQUALIZER_AB, 8'haa);
    chk("detach", {detached, eab_r}, 9'h1aa);
    // Same select as last row, so no reset from the board
    // Enable and transmitter straps move, so a reload would show
    strap_word = 8'he0;
    tick(3);
    chk("frozen", {hs_r, tx_r}, 16'h030f);
    chk("frozen_eq", ecd_r, 8'hff);
    ser(1'b1, `IDX_INPUT_TERM_AB, 8'h5a);
    chk("term_write", term_on, 16'h005a);
    ser(1'b1, `IDX_RECEIVER_SETTINGS, 8'h00);
    chk("term_master", term_on, 16'h0000);
    ser(1'b0, `IDX_INPUT_TERM_AB, 8'h00);
    chk("read_back", ser_rdata, 8'h5a);
    ser(1'b0, `IDX_TRANSMITTER_SETTINGS, 8'h00);
    chk("read_tx", ser_rdata, 8'h0f);
    reset_req = 1'b1;
    tick(2);
    reset_req = 1'b0;
    tick(2);
    chk("reattach", {detached, hs_r, tx_r}, {1'b0, 8'h43, 8'h00});
    chk("term_reload", {rx_r, tab_r, term_on}, {8'h01, 8'h00, 16'h0000});
    test_done;
  end
endmodule
